// ---- hdl/adc_seq_pkg.sv ----
package adc_seq_pkg;

    // ==========================================================
    // Clocking
    // ==========================================================
    localparam int SYS_HZ       = 250_000_000;
    localparam int OSC_HZ       = 1_000_000;
    localparam int OSC_DIV      = SYS_HZ / OSC_HZ;
    localparam int OSC_CNT_BITS = $clog2(OSC_DIV);
    localparam int MOD_DIV      = 4;
    localparam int MOD_HZ       = OSC_HZ / MOD_DIV;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int CODE_BITS   = 12;
    localparam int CODE_FULL   = 1 << (CODE_BITS - 1);
    localparam int LEN_BITS    = 12;
    localparam int SCALE_SHIFT = 16;
    localparam int SCALE_BITS  = 22;

    // ==========================================================
    // Configuration
    // ==========================================================
    typedef struct packed {
        logic       continuous;
        logic [2:0] input_select_field;
        logic [2:0] output_rate_setting;
    } cfg_type;

    localparam cfg_type CFG_DEFAULT = '{continuous:          1'b0,
                                        input_select_field:  3'h0,
                                        output_rate_setting: 3'h4};

    // ==========================================================
    // Input routing
    // ==========================================================
    typedef struct packed {
        logic [1:0] positive_input;
        logic [1:0] negative_input;
        logic       negative_to_ground;
    } mux_route_type;

    localparam logic [1:0] AIN_0 = 2'h0;
    localparam logic [1:0] AIN_1 = 2'h1;
    localparam logic [1:0] AIN_2 = 2'h2;
    localparam logic [1:0] AIN_3 = 2'h3;

    localparam mux_route_type ROUTE_FIXED = '{positive_input:     AIN_0,
                                              negative_input:     AIN_1,
                                              negative_to_ground: 1'b0};

    // Codes 0..3 differential, 4..7 single-ended on inputs 0..3
    function automatic mux_route_type mux_route(input logic [2:0] sel);
        mux_route_type r;
        r = ROUTE_FIXED;
        case (sel)
            3'h0: r = '{AIN_0, AIN_1, 1'b0};
            3'h1: r = '{AIN_0, AIN_3, 1'b0};
            3'h2: r = '{AIN_1, AIN_3, 1'b0};
            3'h3: r = '{AIN_2, AIN_3, 1'b0};
            default: r = '{sel[1:0], AIN_0, 1'b1};
        endcase
        return r;
    endfunction

    // ==========================================================
    // Output rate table
    // ==========================================================
    function automatic int rate_sps(input logic [2:0] r);
        int sps;
        case (r)
            3'h0: sps = 128;
            3'h1: sps = 250;
            3'h2: sps = 490;
            3'h3: sps = 920;
            3'h4: sps = 1600;
            3'h5: sps = 2400;
            default: sps = 3300;
        endcase
        return sps;
    endfunction

    // Modulator ticks per conversion, one settled result each
    function automatic logic [LEN_BITS-1:0] conv_len(input logic [2:0] r);
        int n;
        n = MOD_HZ / rate_sps(r);
        return LEN_BITS'(n);
    endfunction

    // Fixed-point gain turning a count of n into full scale
    function automatic logic [SCALE_BITS-1:0] conv_scale(
        input logic [2:0] r);
        int k;
        k = (CODE_FULL << SCALE_SHIFT) / (MOD_HZ / rate_sps(r));
        return SCALE_BITS'(k);
    endfunction

endpackage

// ---- hdl/delta_filter.sv ----
`timescale 1ns/10ps

module delta_filter #(
    parameter int LEN_BITS    = adc_seq_pkg::LEN_BITS,
    parameter int SCALE_BITS  = adc_seq_pkg::SCALE_BITS,
    parameter int CODE_BITS   = adc_seq_pkg::CODE_BITS,
    parameter int SCALE_SHIFT = adc_seq_pkg::SCALE_SHIFT
) (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rstn,
    // Control
    input  wire logic                        clr,
    input  wire logic                        tick,
    input  wire logic                        last,
    input  wire logic                        bit_in,
    input  wire logic [SCALE_BITS-1:0]       scale,
    // Result
    output logic signed [CODE_BITS-1:0]      code,
    output logic                             code_valid
);

    localparam int PW = LEN_BITS + SCALE_BITS + 2;
    localparam logic signed [PW-1:0] CMAX = PW'((1 << (CODE_BITS-1)) - 1);
    localparam logic signed [PW-1:0] CMIN = PW'(-(1 << (CODE_BITS-1)));

    logic signed [LEN_BITS:0]   acc_r;
    logic signed [LEN_BITS:0]   sum_r;
    logic signed [LEN_BITS:0]   delta;
    logic        [SCALE_BITS-1:0] scale_r;
    logic signed [PW-1:0]       prod_r;
    logic signed [PW-1:0]       shr;
    logic                       sum_vld_r;
    logic                       prod_vld_r;

    // Each modulator bit counts as +1 or -1
    assign delta = bit_in ? (LEN_BITS+1)'(1) : -(LEN_BITS+1)'(1);
    assign shr   = prod_r >>> SCALE_SHIFT;

    // ==========================================================
    // Accumulate; a finished sum is handed on and the next starts
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acc_r     <= '0;
            sum_r     <= '0;
            scale_r   <= '0;
            sum_vld_r <= 1'b0;
        end else begin
            sum_vld_r <= 1'b0;
            if (clr) begin
                acc_r <= '0;
            end else if (tick && last) begin
                acc_r     <= '0;
                sum_r     <= acc_r + delta;
                scale_r   <= scale;   // Rate may change on restart
                sum_vld_r <= 1'b1;
            end else if (tick) begin
                acc_r <= acc_r + delta;
            end
        end
    end

    // Scale to code, then saturate: all ones rounds down to full scale, never past it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prod_r     <= '0;
            prod_vld_r <= 1'b0;
            code       <= '0;
            code_valid <= 1'b0;
        end else begin
            prod_vld_r <= sum_vld_r && !clr;
            prod_r     <= PW'(sum_r * $signed({1'b0, scale_r}));
            code_valid <= prod_vld_r && !clr;
            if (shr > CMAX) begin
                code <= CMAX[CODE_BITS-1:0];
            end else if (shr < CMIN) begin
                code <= CMIN[CODE_BITS-1:0];
            end else begin
                code <= shr[CODE_BITS-1:0];
            end
        end
    end

endmodule // delta_filter

// ---- hdl/adc_conversion_sequencer.sv ----
`timescale 1ns/10ps

// Summary of operation
// [R1] Single-shot: one conversion per request, store result, then power down.
// [R2] Continuous: next conversion starts right after the previous completes.
// [R3] Continuous completion rate equals the selected output rate.
// [R4] Result register always readable, holds the latest completed result.
// [R5] Three-bit select gives four single-ended or two differential inputs.
// [R6] Select also offers input 0 and input 1 against input 3.
// [R7] Single-ended selections tie the negative side to ground.
// [R8] Without multiplexer, always convert input 0 against input 1.
// [R9] Modulator clock is the 1 MHz oscillator divided by four.
// [R10] Filter turns the bitstream into a 12-bit proportional code.
// [R11] Rates offered: 128, 250, 490, 920, 1600, 2400, 3300 per second.
// [R12] One conversion lasts one period of the selected output rate.
// [R13] After reset: default settings, powered down, interface still live.
// [R14] General-call reset acts exactly like a power-up reset; route, len_r and scale_r are not reset here.
// [R15] Select and rate are captured at start, changes apply next time.

module adc_conversion_sequencer #(
    parameter bit HAS_MUX = 1'b1
) (
    // Clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           rstn,
    // Requests from the serial interface logic
    input  wire logic                           cfg_wr,
    input  wire adc_seq_pkg::cfg_type           cfg_in,
    input  wire logic                           start_req,
    input  wire logic                           gen_call_reset,
    // Modulator side
    input  wire logic                           mod_bit_pin,
    output logic                                modulator_clock,
    output adc_seq_pkg::mux_route_type          route,
    // Status and result
    output adc_seq_pkg::cfg_type                cfg_out,
    output logic                                busy,
    output logic                                conv_done,
    output logic signed [adc_seq_pkg::CODE_BITS-1:0] result
);

    typedef enum logic [1:0] {ST_PDOWN, ST_CONV, ST_FLUSH} state_type;

    state_type                                state_r;
    adc_seq_pkg::cfg_type                     cfg_r;
    logic [adc_seq_pkg::OSC_CNT_BITS-1:0]     osc_cnt_r;
    logic [1:0]                               mod_phase_r;
    logic                                     osc_tick;
    logic                                     mod_tick;
    logic [adc_seq_pkg::LEN_BITS-1:0]         len_r;
    logic [adc_seq_pkg::LEN_BITS-1:0]         cnt_r;
    logic [adc_seq_pkg::SCALE_BITS-1:0]       scale_r;
    logic [2:0]                               bit_sync_r;
    logic                                     bit_r;
    logic                                     last;
    logic                                     start_now;
    logic                                     filt_clr;
    logic signed [adc_seq_pkg::CODE_BITS-1:0] code;
    logic                                     code_valid;
    logic                                     soft_rst;

    assign soft_rst = gen_call_reset;                        // [R14]

    // ==========================================================
    // Configuration store
    // ==========================================================
    // Same defaults on power-up and on a general-call reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= adc_seq_pkg::CFG_DEFAULT;               // [R13]
        end else if (soft_rst) begin
            cfg_r <= adc_seq_pkg::CFG_DEFAULT;               // [R14]
        end else if (cfg_wr) begin
            cfg_r <= cfg_in;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_out <= adc_seq_pkg::CFG_DEFAULT;
        end else begin
            cfg_out <= cfg_r;
        end
    end

    // ==========================================================
    // Oscillator and modulator clock
    // ==========================================================
    // Kept running in power-down; only the conversion logic idles
    assign osc_tick = (osc_cnt_r ==
                       adc_seq_pkg::OSC_CNT_BITS'(adc_seq_pkg::OSC_DIV - 1));
    assign mod_tick = osc_tick &&
                      (mod_phase_r == 2'(adc_seq_pkg::MOD_DIV - 1)); // [R9]

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            osc_cnt_r   <= '0;
            mod_phase_r <= '0;
        end else if (osc_tick) begin
            osc_cnt_r   <= '0;
            mod_phase_r <= mod_phase_r + 2'h1;               // [R9]
        end else begin
            osc_cnt_r <= osc_cnt_r + 1'b1;
        end
    end

    // Half-duty square wave at the modulator rate
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            modulator_clock <= 1'b0;
        end else begin
            modulator_clock <= mod_phase_r[1];               // [R9]
        end
    end

    // ==========================================================
    // Modulator bit synchroniser
    // ==========================================================
    // Stage 0 feeds stage 1 only; a change counts once 1 and 2 agree
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bit_sync_r <= '0;
            bit_r      <= 1'b0;
        end else begin
            bit_sync_r <= {bit_sync_r[1:0], mod_bit_pin};
            if (bit_sync_r[1] == bit_sync_r[2]) begin
                bit_r <= bit_sync_r[2];
            end
        end
    end

    // ==========================================================
    // Conversion sequencing
    // ==========================================================
    assign last      = (state_r == ST_CONV) && mod_tick &&
                       (cnt_r == len_r - 1'b1);              // [R12]
    // Continuous mode needs no request; single-shot only when idle
    assign start_now = (state_r == ST_PDOWN) &&
                       (cfg_r.continuous || start_req);      // [R1] [R2]
    assign filt_clr  = soft_rst || start_now;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_PDOWN;                             // [R13]
        end else if (soft_rst) begin
            state_r <= ST_PDOWN;                             // [R14]
        end else begin
            case (state_r)
                ST_PDOWN: begin
                    if (start_now) begin
                        state_r <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    // Back to back: restart on the final tick
                    if (last && !cfg_r.continuous) begin
                        state_r <= ST_FLUSH;                 // [R1]
                    end
                end
                ST_FLUSH: begin
                    if (code_valid) begin
                        state_r <= ST_PDOWN;                 // [R1]
                    end
                end
                default: state_r <= ST_PDOWN;
            endcase
        end
    end

    // Snapshot of select and rate, taken as each conversion begins
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            len_r   <= adc_seq_pkg::conv_len(
                           adc_seq_pkg::CFG_DEFAULT.output_rate_setting);
            scale_r <= '0;
            route   <= adc_seq_pkg::ROUTE_FIXED;
        end else if (start_now || (last && cfg_r.continuous)) begin
            len_r   <= adc_seq_pkg::conv_len(
                           cfg_r.output_rate_setting);       // [R15] [R11]
            scale_r <= adc_seq_pkg::conv_scale(
                           cfg_r.output_rate_setting);       // [R15]
            if (HAS_MUX) begin
                route <= adc_seq_pkg::mux_route(
                             cfg_r.input_select_field);      // [R5] [R6] [R7]
            end else begin
                route <= adc_seq_pkg::ROUTE_FIXED;           // [R8]
            end
        end
    end

    // Modulator ticks into the current conversion
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else if (soft_rst || start_now || last) begin
            cnt_r <= '0;                                     // [R2]
        end else if (state_r == ST_CONV && mod_tick) begin
            cnt_r <= cnt_r + 1'b1;                           // [R3]
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_r != ST_PDOWN) && !soft_rst;
        end
    end

    // ==========================================================
    // Filter and result
    // ==========================================================
    delta_filter u_filter (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .clr        (filt_clr),
        .tick       ((state_r == ST_CONV) && mod_tick),
        .last       (last),
        .bit_in     (bit_r),
        .scale      (scale_r),
        .code       (code),                                  // [R10]
        .code_valid (code_valid)
    );

    // Whole words only: partial sums never reach the result
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            result    <= '0;
            conv_done <= 1'b0;
        end else if (soft_rst) begin
            result    <= '0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= code_valid;
            if (code_valid) begin
                result <= code;                              // [R4]
            end
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    single_pdown_a: assert property (                        // [R1]
        @(posedge sys_clk) disable iff (!rstn)
        (last && !cfg_r.continuous && !soft_rst)
            |=> (state_r == ST_FLUSH) ##[1:4] (state_r == ST_PDOWN))
        else $error("single-shot did not power down");

    cont_restart_a: assert property (                        // [R2]
        @(posedge sys_clk) disable iff (!rstn)
        (last && cfg_r.continuous && !soft_rst)
            |=> (state_r == ST_CONV) && (cnt_r == '0))
        else $error("continuous conversion did not restart");

    // A missed final tick would let the count run past its length
    conv_length_a: assert property (                         // [R3] [R12]
        @(posedge sys_clk) disable iff (!rstn)
        (state_r == ST_CONV) |-> (cnt_r < len_r))
        else $error("conversion ran past its length");

    result_hold_a: assert property (                         // [R4]
        @(posedge sys_clk) disable iff (!rstn)
        (!code_valid && !soft_rst) |=> $stable(result))
        else $error("result changed without completion");

    done_pulse_a: assert property (                          // [R4]
        @(posedge sys_clk) disable iff (!rstn)
        conv_done |=> !conv_done)
        else $error("done pulse longer than one cycle");

    ground_switch_a: assert property (                       // [R7]
        @(posedge sys_clk) disable iff (!rstn)
        (HAS_MUX && start_now && cfg_r.input_select_field[2]
            && !soft_rst)
            |=> route.negative_to_ground
                && route.negative_input == adc_seq_pkg::AIN_0)
        else $error("single-ended negative side not grounded");

    fixed_pair_a: assert property (                          // [R8]
        @(posedge sys_clk) disable iff (!rstn)
        !HAS_MUX |-> route == adc_seq_pkg::ROUTE_FIXED)
        else $error("fixed pair not selected");

    mod_divide_a: assert property (                          // [R9]
        @(posedge sys_clk) disable iff (!rstn)
        mod_tick |=> !mod_tick [*8])
        else $error("modulator ticks too close");

    gen_reset_a: assert property (                           // [R14]
        @(posedge sys_clk) disable iff (!rstn)
        soft_rst |=> state_r == ST_PDOWN
            && cfg_r == adc_seq_pkg::CFG_DEFAULT && !conv_done)
        else $error("general-call reset incomplete");

    snapshot_hold_a: assert property (                       // [R15]
        @(posedge sys_clk) disable iff (!rstn)
        (state_r == ST_CONV && !last && !soft_rst)
            |=> $stable(len_r) && $stable(route))
        else $error("settings changed mid-conversion");

endmodule // adc_conversion_sequencer

// ---- dv/modulator_model.sv ----
`timescale 1ns/10ps

// ==========================================================
// Far-side modulator bitstream source
// ==========================================================
module modulator_model (
    // Modulator clock from the block
    input  wire logic       modulator_clock,
    // Pattern: 0 all ones, 1 all zeros, else alternating
    input  wire logic [1:0] pattern,
    // Bitstream back to the block
    output logic            mod_bit_pin
);
    logic toggle_r;

    // Power-up state of the bitstream
    initial begin
        toggle_r    = 1'b0;
        mod_bit_pin = 1'b1;
    end

    // New bit after a falling edge, so it is stable at the rising one
    always @(negedge modulator_clock) begin
        toggle_r    <= ~toggle_r;
        mod_bit_pin <= (pattern == 2'h0) ? 1'b1 :
                       (pattern == 2'h1) ? 1'b0 : toggle_r;
    end
endmodule // modulator_model

// ---- dv/adc_conversion_sequencer_bench.sv ----
`timescale 1ns/10ps

module adc_conversion_sequencer_bench;
    // ==========================================================
    // Signals
    // ==========================================================
    logic                                     sys_clk;
    logic                                     rstn;
    logic                                     cfg_wr;
    logic                                     start_req;
    logic                                     gen_call_reset;
    logic                                     mod_bit_pin;
    logic                                     modulator_clock;
    logic                                     busy;
    logic                                     conv_done;
    logic [1:0]                               pattern;
    adc_seq_pkg::cfg_type                     cfg_in;
    adc_seq_pkg::cfg_type                     cfg_out;
    adc_seq_pkg::mux_route_type               route;
    adc_seq_pkg::mux_route_type               route_fixed;
    logic signed [adc_seq_pkg::CODE_BITS-1:0] result;
    int                                       num_errors;
    int                                       checked;
    int                                       cycles = 0;

    // ==========================================================
    // Instances
    // ==========================================================
    adc_conversion_sequencer #(.HAS_MUX(1'b1)) adc_conversion_sequencer_inst (
        .sys_clk(sys_clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
        .start_req(start_req), .gen_call_reset(gen_call_reset),
        .mod_bit_pin(mod_bit_pin), .modulator_clock(modulator_clock),
        .route(route), .cfg_out(cfg_out), .busy(busy),
        .conv_done(conv_done), .result(result));

    // Variant without multiplexer shares every input
    adc_conversion_sequencer #(.HAS_MUX(1'b0)) adc_fixed_inst (
        .sys_clk(sys_clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
        .start_req(start_req), .gen_call_reset(gen_call_reset),
        .mod_bit_pin(mod_bit_pin), .modulator_clock(),
        .route(route_fixed), .cfg_out(), .busy(),
        .conv_done(), .result());

    modulator_model modulator_model_inst (
        .modulator_clock(modulator_clock), .pattern(pattern),
        .mod_bit_pin(mod_bit_pin));

    // ==========================================================
    // Clock and watchdog
    // ==========================================================
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Longest path is one 3300 rate conversion, about 75000 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            num_errors++;
            results();
        end
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic write_cfg(input logic cont, input logic [2:0] sel,
                             input logic [2:0] rate);
        @(posedge sys_clk);
        cfg_in <= '{continuous: cont, input_select_field: sel,
                    output_rate_setting: rate};
        cfg_wr <= 1'b1;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
    endtask

    task automatic pulse_start;
        @(posedge sys_clk);
        start_req <= 1'b1;
        @(posedge sys_clk);
        start_req <= 1'b0;
    endtask

    // Soft reset then wait for the default config to show
    task automatic pulse_reset;
        @(posedge sys_clk);
        gen_call_reset <= 1'b1;
        @(posedge sys_clk);
        gen_call_reset <= 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask

    // Bounded wait for busy, then judge its level
    task automatic wait_busy(input logic lvl);
        int i;
        i = 0;
        @(negedge sys_clk);
        while (busy !== lvl && i < 20) begin
            @(negedge sys_clk);
            i++;
        end
        check(12'(busy), 12'(lvl));
    endtask

    // Route per select code: differential pairs, then n against ground
    function automatic logic [4:0] exp_route(input logic [2:0] s);
        case (s)
            3'h0: return 5'h02;
            3'h1: return 5'h06;
            3'h2: return 5'h0e;
            3'h3: return 5'h16;
            default: return {s[1:0], 2'h0, 1'b1};
        endcase
    endfunction

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic test_reset;
        repeat (50) @(negedge sys_clk);
        check(12'(cfg_out), 12'(adc_seq_pkg::CFG_DEFAULT));
        check(12'(busy), 12'h000);
        check(12'(result), 12'h000);
        check(12'(route), 12'(adc_seq_pkg::ROUTE_FIXED));
    endtask

    task automatic test_modclk;
        time t0;
        @(posedge modulator_clock);
        t0 = $time;
        @(negedge modulator_clock);
        check(12'(($time - t0) / 4), 12'h1f4);
        @(posedge modulator_clock);
        check(12'(($time - t0) / 4), 12'h3e8);
    endtask

    // Every select code, aborted by the soft reset each time
    task automatic test_routes;
        for (int s = 0; s < 8; s++) begin
            write_cfg(1'b0, 3'(s), 3'h6);
            pulse_start;
            wait_busy(1'b1);
            check(12'(route), 12'(exp_route(3'(s))));
            check(12'(route_fixed), 12'h002);
            pulse_reset;
            check(12'(busy), 12'h000);
            check(12'(cfg_out), 12'(adc_seq_pkg::CFG_DEFAULT));
        end
    endtask

    // Full-scale single shot with a mid-run config change and an ignored restart request
    task automatic test_single;
        int   n;
        logic held_ok;
        n = 0;
        held_ok = 1'b1;
        write_cfg(1'b0, 3'h4, 3'h6);
        pulse_start;
        wait_busy(1'b1);
        write_cfg(1'b0, 3'h1, 3'h0);
        pulse_start;
        while (conv_done !== 1'b1 && n < 80000) begin
            @(negedge sys_clk);
            n++;
            if (conv_done !== 1'b1 && result !== 12'sh000) held_ok = 1'b0;
        end
        check(12'(result), 12'h7ff);
        check(12'(held_ok), 12'h001);
        check(12'(n >= 74000 && n <= 76100), 12'h001);
        check(12'(route), 12'h001);
        @(negedge sys_clk);
        check(12'(conv_done), 12'h000);
        check(12'(busy), 12'h000);
        repeat (2000) @(negedge sys_clk);
        check(12'(busy), 12'h000);
        check(12'(result), 12'h7ff);
    endtask

    // Continuous mode starts on its own from power-down
    task automatic test_continuous;
        write_cfg(1'b1, 3'h2, 3'h6);
        wait_busy(1'b1);
        check(12'(route), 12'h00e);
        pulse_reset;
        check(12'(busy), 12'h000);
        check(12'(result), 12'h000);
    endtask

    // ==========================================================
    // Closing report and main sequence
    // ==========================================================
    task automatic results;
        $display("Counts: %0d errors in %0d checks", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        rstn           = 1'b0;
        cfg_wr         = 1'b0;
        cfg_in         = adc_seq_pkg::CFG_DEFAULT;
        start_req      = 1'b0;
        gen_call_reset = 1'b0;
        pattern        = 2'h0;
        num_errors     = 0;
        checked        = 0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        test_reset;
        test_modclk;
        test_routes;
        test_single;
        test_continuous;
        results;
    end
endmodule // adc_conversion_sequencer_bench
